// ### hw/rcs_pkg.sv
package rcs_pkg;

    // Resolved state of a four-level strap
    typedef enum logic [1:0] {
        LVL_LOW   = 2'b00,
        LVL_R20K  = 2'b01,
        LVL_FLOAT = 2'b10,
        LVL_HIGH  = 2'b11
    } rcs_lvl_t;

    typedef enum logic [1:0] {
        CFG_PIN    = 2'b00,
        CFG_SLAVE  = 2'b01,
        CFG_MASTER = 2'b10
    } rcs_cfg_t;

    typedef enum logic [1:0] {
        OPM_SAS   = 2'b00,
        OPM_ESATA = 2'b01,
        OPM_SLOW  = 2'b10,
        OPM_CONT  = 2'b11
    } rcs_opm_t;

    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_BUSY = 2'b01,
        LD_DONE = 2'b10,
        LD_FAIL = 2'b11
    } rcs_ld_t;

    // Pad codes of the control pins
    typedef struct packed {
        rcs_lvl_t mgmt_bus_enable_strap;
        rcs_lvl_t output_swing_select;
        rcs_lvl_t op_mode_strap;
        rcs_lvl_t signal_detect_threshold;
        rcs_lvl_t chan_a_eq_level_bit0;
        rcs_lvl_t chan_a_eq_level_bit1;
        rcs_lvl_t chan_b_eq_level_bit0;
        rcs_lvl_t chan_b_eq_level_bit1;
        rcs_lvl_t chan_a_deemph_level;
        rcs_lvl_t chan_b_deemph_level;
        logic     eeprom_read_request_n;
        logic     transmit_disable;
        logic     input_a_present;
        logic     input_b_present;
    } rcs_pins_t;

    typedef struct packed {
        logic       swing_1v3;
        logic [1:0] los_src;
        logic       dem_indep;
        logic [3:0] dem_b;
        logic [3:0] dem_a;
        logic [3:0] eq_b;
        logic [3:0] eq_a;
    } rcs_ctrl_t;

    typedef struct packed {
        logic [7:0] slave_addr;
        logic       loss;
        logic       low_power;
        rcs_ld_t    ld;
        rcs_opm_t   opm;
        rcs_cfg_t   cfg;
    } rcs_stat_t;

    // Settings handed to the analog lanes
    typedef struct packed {
        logic [3:0]  eq_a;
        logic [3:0]  eq_b;
        logic [3:0]  dem_a;
        logic [3:0]  dem_b;
        logic [10:0] swing_a_mv;
        logic [10:0] swing_b_mv;
        logic [7:0]  thr_assert_mv;
        logic [7:0]  thr_deassert_mv;
        rcs_opm_t    opm;
        logic        low_power;
        logic        output_a_en;
        logic        output_b_en;
    } rcs_ana_t;

    localparam int unsigned IDLE_CNT_W = 16;

    typedef struct packed {
        rcs_pins_t               s1;
        rcs_pins_t               s2;
        rcs_pins_t               s3;
        rcs_pins_t               flt;
        logic                    rd_prev;
        rcs_ctrl_t               ctrl;
        logic [31:0]             prdata;
        rcs_ld_t                 ld;
        logic                    fetch_start;
        logic [IDLE_CNT_W-1:0]   idle_cnt;
        rcs_cfg_t                cfg;
        logic [7:0]              addr;
        logic                    loss;
        logic                    scl_en;
        logic                    sda_en;
        rcs_ana_t                ana;
    } rcs_state_t;

    localparam int unsigned PINS_W = $bits(rcs_pins_t);
    localparam int unsigned CTRL_W = $bits(rcs_ctrl_t);
    localparam int unsigned STAT_W = $bits(rcs_stat_t);

    // Register map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STAT = 12'h004;
    localparam rcs_ctrl_t   CTRL_RST = '0;

    localparam logic [1:0] LOS_SRC_A   = 2'h0;
    localparam logic [1:0] LOS_SRC_B   = 2'h1;
    localparam logic [1:0] LOS_SRC_ANY = 2'h2;

    localparam logic [7:0] ADDR_BASE  = 8'hb0;
    localparam logic [7:0] ADDR_FIXED = 8'hb0;

    localparam logic [10:0] SWING_LOW_MV    = 11'h2bc;
    localparam logic [10:0] SWING_FLOAT_MV  = 11'h3e8;
    localparam logic [10:0] SWING_R20K_MV   = 11'h4b0;
    localparam logic [10:0] SWING_HI_MV     = 11'h44c;
    localparam logic [10:0] SWING_HI_ALT_MV = 11'h514;

    localparam logic [7:0] THR_R20K_AS  = 8'ha0;
    localparam logic [7:0] THR_R20K_DE  = 8'h64;
    localparam logic [7:0] THR_FLOAT_AS = 8'hb4;
    localparam logic [7:0] THR_FLOAT_DE = 8'h6e;
    localparam logic [7:0] THR_HIGH_AS  = 8'hbe;
    localparam logic [7:0] THR_HIGH_DE  = 8'h82;
    localparam logic [7:0] THR_LOW_AS   = 8'hd2;
    localparam logic [7:0] THR_LOW_DE   = 8'h96;

    // Inactivity time before auto low power
    localparam int unsigned CLK_MHZ       = 10;
    localparam int unsigned INACT_TIME_US = 100;
    localparam int unsigned INACT_CYC_DEF = INACT_TIME_US * CLK_MHZ;

endpackage : rcs_pkg

// ### hw/rcs_strap_decode.sv
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module rcs_strap_decode
    import rcs_pkg::*;
#(
    parameter int unsigned INACT_CYCLES = INACT_CYC_DEF
)(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Control pins as resolved pad codes
    input  wire rcs_pins_t   pad_in,
    // Shared pins driven as bus clock and data
    output logic             scl_pull,
    output logic             scl_pull_en,
    output logic             sda_pull,
    output logic             sda_pull_en,
    // Bus engine side
    output logic             smb_scl_level,
    output logic             smb_sda_level,
    output logic      [7:0]  smb_slave_addr,
    output rcs_cfg_t         smb_mode,
    input  wire logic        smb_scl_drive_low,
    input  wire logic        smb_sda_drive_low,
    // EEPROM load
    output logic             eeprom_fetch_start,
    input  wire logic        eeprom_fetch_done,
    input  wire logic        eeprom_fetch_error,
    output logic             eeprom_load_status,
    // Status and lane settings
    output logic             loss_of_signal_out,
    output logic             loss_of_signal_out_en,
    output rcs_ana_t         ana
);

    rcs_state_t      st_ff;
    rcs_state_t      nxt_st;
    rcs_pins_t       p;
    logic [PINS_W-1:0] diff;
    rcs_cfg_t        cfg;
    logic            smb;
    logic [3:0]      slave_addr_straps;
    logic            acc;
    logic            hit_ctrl;
    logic            hit_stat;
    logic            rd_fall;
    logic            idle;
    logic [15:0]     thr;
    rcs_stat_t       stat;

    ////////////////////////////////////////////////////////////////////////
    // Decode tables

    function automatic logic [10:0] swing_of(rcs_lvl_t lvl, logic alt);
        logic [10:0] mv;
        case (lvl)
            LVL_HIGH:  mv = alt ? SWING_HI_ALT_MV : SWING_HI_MV;
            LVL_FLOAT: mv = SWING_FLOAT_MV;
            LVL_R20K:  mv = SWING_R20K_MV;
            default:   mv = SWING_LOW_MV;
        endcase
        return mv;
    endfunction : swing_of

    function automatic logic [15:0] thr_of(rcs_lvl_t lvl);
        logic [15:0] t;
        case (lvl)
            LVL_R20K:  t = {THR_R20K_AS, THR_R20K_DE};
            LVL_HIGH:  t = {THR_HIGH_AS, THR_HIGH_DE};
            LVL_LOW:   t = {THR_LOW_AS, THR_LOW_DE};
            default:   t = {THR_FLOAT_AS, THR_FLOAT_DE};
        endcase
        return t;
    endfunction : thr_of

    ////////////////////////////////////////////////////////////////////////
    // APB decode, zero wait states

    assign acc      = psel & penable;
    assign hit_ctrl = (paddr == REG_CTRL);
    assign hit_stat = (paddr == REG_STAT);
    assign prdata   = st_ff.prdata;
    assign pready   = 1'b1;
    assign pslverr  = acc & ~(hit_ctrl | hit_stat);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        nxt_st = st_ff;
        p      = st_ff.flt;
        nxt_st.s1  = pad_in;
        nxt_st.s2  = st_ff.s1;
        nxt_st.s3  = st_ff.s2;
        diff       = st_ff.s2 ^ st_ff.s3;
        nxt_st.flt = rcs_pins_t'((st_ff.s2 & ~diff) | (st_ff.flt & diff));

        case (p.mgmt_bus_enable_strap)
            LVL_HIGH:  cfg = CFG_SLAVE;
            LVL_FLOAT: cfg = CFG_MASTER;
            default:   cfg = CFG_PIN;
        endcase
        smb        = (cfg != CFG_PIN);
        nxt_st.cfg = cfg;

        // address straps share the eq pins
        slave_addr_straps = {p.chan_b_eq_level_bit1 == LVL_HIGH,
                             p.chan_b_eq_level_bit0 == LVL_HIGH,
                             p.chan_a_eq_level_bit1 == LVL_HIGH,
                             p.chan_a_eq_level_bit0 == LVL_HIGH};
        if (p.output_swing_select == LVL_HIGH)
            nxt_st.addr = ADDR_FIXED;
        else
            nxt_st.addr = ADDR_BASE + {3'h0, slave_addr_straps, 1'b0};

        // Register access
        if (acc && pwrite && hit_ctrl)
            nxt_st.ctrl = rcs_ctrl_t'(pwdata[CTRL_W-1:0]);
        stat = '{slave_addr: st_ff.addr, loss: st_ff.loss,
                 low_power: st_ff.ana.low_power, ld: st_ff.ld,
                 opm: st_ff.ana.opm, cfg: st_ff.cfg};
        if (psel && !penable && !pwrite)
        begin
            if (hit_ctrl)
                nxt_st.prdata = {{(32-CTRL_W){1'b0}}, st_ff.ctrl};
            else if (hit_stat)
                nxt_st.prdata = {{(32-STAT_W){1'b0}}, stat};
            else
                nxt_st.prdata = '0;
        end

        // start on falling edge of the read request
        nxt_st.rd_prev     = p.eeprom_read_request_n;
        rd_fall            = st_ff.rd_prev & ~p.eeprom_read_request_n;
        nxt_st.fetch_start = 1'b0;
        case (st_ff.ld)
            LD_IDLE, LD_DONE, LD_FAIL:
            begin
                if (rd_fall && cfg == CFG_MASTER)
                begin
                    nxt_st.ld          = LD_BUSY;
                    nxt_st.fetch_start = 1'b1;
                end
            end
            LD_BUSY:
            begin
                if (eeprom_fetch_error)
                    nxt_st.ld = LD_FAIL;
                else if (eeprom_fetch_done)
                    nxt_st.ld = LD_DONE;
            end
            default: nxt_st.ld = LD_IDLE;
        endcase

        if (smb)
        begin
            nxt_st.ana.eq_a = st_ff.ctrl.eq_a;
            nxt_st.ana.eq_b = st_ff.ctrl.eq_b;
        end
        else
        begin
            nxt_st.ana.eq_a = {p.chan_a_eq_level_bit1, p.chan_a_eq_level_bit0};
            nxt_st.ana.eq_b = {p.chan_b_eq_level_bit1, p.chan_b_eq_level_bit0};
        end

        // one shared level unless registers split it
        if (smb)
        begin
            nxt_st.ana.dem_a = st_ff.ctrl.dem_a;
            nxt_st.ana.dem_b = st_ff.ctrl.dem_indep ? st_ff.ctrl.dem_b
                                                    : st_ff.ctrl.dem_a;
        end
        else
        begin
            nxt_st.ana.dem_a = {p.chan_b_deemph_level, p.chan_a_deemph_level};
            nxt_st.ana.dem_b = {p.chan_b_deemph_level, p.chan_a_deemph_level};
        end

        // open-drain pulls only in bus mode
        nxt_st.scl_en = smb & smb_scl_drive_low;
        nxt_st.sda_en = smb & smb_sda_drive_low;

        nxt_st.ana.swing_b_mv = swing_of(p.output_swing_select,
                                         smb & st_ff.ctrl.swing_1v3);
        // output A capped in pin mode
        if (smb)
            nxt_st.ana.swing_a_mv = nxt_st.ana.swing_b_mv;
        else
            nxt_st.ana.swing_a_mv = SWING_LOW_MV;

        nxt_st.ana.output_a_en = 1'b1;
        nxt_st.ana.output_b_en = ~p.transmit_disable;

        case (p.op_mode_strap)
            LVL_HIGH:  nxt_st.ana.opm = OPM_CONT;
            LVL_FLOAT: nxt_st.ana.opm = OPM_SLOW;
            LVL_R20K:  nxt_st.ana.opm = OPM_ESATA;
            default:   nxt_st.ana.opm = OPM_SAS;
        endcase

        // idle timer; signal detect keeps running meanwhile
        idle = ~p.input_a_present & ~p.input_b_present;
        if (!idle || st_ff.ana.opm != OPM_ESATA)
        begin
            nxt_st.idle_cnt      = '0;
            nxt_st.ana.low_power = 1'b0;
        end
        else if (st_ff.idle_cnt == IDLE_CNT_W'(INACT_CYCLES - 1))
            nxt_st.ana.low_power = 1'b1;
        else
            nxt_st.idle_cnt = st_ff.idle_cnt + 1'b1;

        // loss source, input A unless registers choose
        case (smb ? st_ff.ctrl.los_src : LOS_SRC_A)
            LOS_SRC_B:   nxt_st.loss = ~p.input_b_present;
            LOS_SRC_ANY: nxt_st.loss = idle | ~p.input_a_present
                                            | ~p.input_b_present;
            default:     nxt_st.loss = ~p.input_a_present;
        endcase

        thr = thr_of(p.signal_detect_threshold);
        nxt_st.ana.thr_assert_mv   = thr[15:8];
        nxt_st.ana.thr_deassert_mv = thr[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff      <= '0;
            st_ff.ctrl <= CTRL_RST;
        end
        else
            st_ff <= nxt_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign scl_pull              = 1'b0;
    assign sda_pull              = 1'b0;
    assign scl_pull_en           = st_ff.scl_en;
    assign sda_pull_en           = st_ff.sda_en;
    assign smb_scl_level         = st_ff.flt.chan_b_deemph_level[1];
    assign smb_sda_level         = st_ff.flt.chan_a_deemph_level[1];
    assign smb_slave_addr        = st_ff.addr;
    assign smb_mode              = st_ff.cfg;
    assign eeprom_fetch_start    = st_ff.fetch_start;
    // high unless a load completed cleanly
    assign eeprom_load_status    = (st_ff.ld != LD_DONE);
    assign loss_of_signal_out    = 1'b0;
    assign loss_of_signal_out_en = ~st_ff.loss;
    assign ana                   = st_ff.ana;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_CFG_SLAVE: assert property (
        st_ff.flt.mgmt_bus_enable_strap == LVL_HIGH |=> smb_mode == CFG_SLAVE)
        else $error("slave strap not decoded");

    AST_ADDR_STRAP: assert property (
        st_ff.flt.output_swing_select != LVL_HIGH |=>
        smb_slave_addr == ADDR_BASE + {3'h0, $past(slave_addr_straps), 1'b0})
        else $error("strapped address wrong");

    AST_ADDR_FORCE: assert property (
        st_ff.flt.output_swing_select == LVL_HIGH |=>
        smb_slave_addr == ADDR_FIXED)
        else $error("forced address missing");

    AST_LOAD_START: assert property (
        rd_fall && cfg == CFG_MASTER && st_ff.ld != LD_BUSY |=>
        eeprom_fetch_start && eeprom_load_status)
        else $error("fetch not started on falling edge");

    AST_LOAD_FAIL: assert property (
        st_ff.ld == LD_BUSY && eeprom_fetch_error |=>
        eeprom_load_status [*2])
        else $error("status low after failed load");

    AST_LOAD_OK: assert property (
        st_ff.ld == LD_BUSY && eeprom_fetch_done && !eeprom_fetch_error
        |=> !eeprom_load_status)
        else $error("status high after clean load");

    AST_DEM_SHARED: assert property (
        cfg == CFG_PIN |=> ana.dem_a == ana.dem_b)
        else $error("pin mode de-emphasis differs");

    AST_PULL_PIN: assert property (
        smb_mode == CFG_PIN |-> !scl_pull_en && !sda_pull_en)
        else $error("bus pins driven in pin mode");

    AST_TXDIS: assert property (
        st_ff.flt.transmit_disable |=> ana.output_a_en && !ana.output_b_en)
        else $error("transmit disable not honoured");

    AST_SWING_A: assert property (
        cfg == CFG_PIN |=> ana.swing_a_mv == SWING_LOW_MV)
        else $error("output A swing not capped");

    AST_IDLE_LP: assert property (
        $rose(ana.low_power) |->
        $past(st_ff.idle_cnt) == IDLE_CNT_W'(INACT_CYCLES - 1))
        else $error("low power entered early");

    AST_THR_DEF: assert property (
        st_ff.flt.signal_detect_threshold == LVL_FLOAT |=>
        ana.thr_assert_mv == THR_FLOAT_AS && ana.thr_deassert_mv == THR_FLOAT_DE)
        else $error("default threshold wrong");

    AST_FILTER: assert property (
        st_ff.s2 == st_ff.s3 |=> st_ff.flt == $past(st_ff.s2))
        else $error("filter missed agreed level");

    COV_LOAD_DONE: cover property (
        eeprom_fetch_start ##[1:20] !eeprom_load_status);
    COV_LOW_POWER: cover property ($rose(ana.low_power));
    COV_FORCED:    cover property (
        smb_mode == CFG_SLAVE && smb_slave_addr == ADDR_FIXED);

endmodule : rcs_strap_decode

// ### verification/rcs_eeprom_model.sv
`timescale 1ns/10ps
module rcs_eeprom_model
    import rcs_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Fetch handshake
    input  wire logic       start,
    input  wire logic [3:0] delay,
    input  wire logic       fail,
    output logic            done,
    output logic            error
);
    logic [3:0] cnt_ff;
    logic       busy_ff;
    ////////////////////////////////////////
    // answer one fetch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
        end
        else if (start)
        begin
            cnt_ff  <= delay;
            busy_ff <= 1'b1;
        end
        else if (busy_ff && cnt_ff != 4'h0)
            cnt_ff <= cnt_ff - 4'h1;
        else
            busy_ff <= 1'b0;
    end
    // One-cycle reply, error or done
    assign done  = busy_ff && cnt_ff == 4'h0 && !fail;
    assign error = busy_ff && cnt_ff == 4'h0 && fail;
endmodule : rcs_eeprom_model

// ### verification/tb.sv
`timescale 1ns/10ps
module tb
    import rcs_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        er, scl_en, sda_en, scl_lv, sda_lv, drv_scl, drv_sda;
    logic        f_start, f_done, f_err, ld_st, los_en, fail;
    logic        scl_o, sda_o, los_o;
    logic [3:0]  dly;
    logic [7:0]  s_addr;
    rcs_cfg_t    s_mode;
    rcs_pins_t   pads;
    rcs_ana_t    ana;
    int          err_count, compares;

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    rcs_strap_decode #(.INACT_CYCLES(8)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_in(pads),
        .scl_pull(scl_o), .scl_pull_en(scl_en), .sda_pull(sda_o),
        .sda_pull_en(sda_en), .smb_scl_level(scl_lv),
        .smb_sda_level(sda_lv), .smb_slave_addr(s_addr),
        .smb_mode(s_mode), .smb_scl_drive_low(drv_scl),
        .smb_sda_drive_low(drv_sda), .eeprom_fetch_start(f_start),
        .eeprom_fetch_done(f_done), .eeprom_fetch_error(f_err),
        .eeprom_load_status(ld_st), .loss_of_signal_out(los_o),
        .loss_of_signal_out_en(los_en), .ana(ana));

    rcs_eeprom_model far (
        .pclk(pclk), .presetn(presetn), .start(f_start), .delay(dly),
        .fail(fail), .done(f_done), .error(f_err));

    ////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Pad filter plus output register
    task automatic settle;
        repeat (6) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic close_out;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    ////////////////////////////////////////
    task automatic sc_regs;
        apb(1'b0, REG_CTRL, '0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h008, 32'hffff_ffff);
        chk(32'(er), 32'h1);
        apb(1'b0, 12'h008, '0);
        chk({rd[30:0], er}, 32'h1);
    endtask : sc_regs

    task automatic sc_cfg;
        rcs_cfg_t e [4] = '{CFG_PIN, CFG_PIN, CFG_MASTER, CFG_SLAVE};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk);
            pads.mgmt_bus_enable_strap <= rcs_lvl_t'(2'(i));
            settle();
            chk(32'(s_mode), 32'(e[i]));
        end
    endtask : sc_cfg

    task automatic sc_pin;
        logic [10:0] sw [4] = '{SWING_LOW_MV, SWING_R20K_MV,
                                SWING_FLOAT_MV, SWING_HI_MV};
        logic [15:0] th [4] = '{{THR_LOW_AS, THR_LOW_DE},
                                {THR_R20K_AS, THR_R20K_DE},
                                {THR_FLOAT_AS, THR_FLOAT_DE},
                                {THR_HIGH_AS, THR_HIGH_DE}};
        rcs_opm_t    op [4] = '{OPM_SAS, OPM_ESATA, OPM_SLOW, OPM_CONT};
        @(posedge pclk);
        pads.mgmt_bus_enable_strap <= LVL_LOW;
        pads.chan_a_eq_level_bit1  <= LVL_FLOAT;
        pads.chan_a_eq_level_bit0  <= LVL_R20K;
        pads.chan_b_eq_level_bit1  <= LVL_HIGH;
        pads.chan_b_deemph_level   <= LVL_R20K;
        pads.chan_a_deemph_level   <= LVL_HIGH;
        settle();
        chk({ana.eq_a, ana.eq_b}, 32'h9c);
        chk({ana.dem_a, ana.dem_b}, 32'h77);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk);
            pads.output_swing_select     <= rcs_lvl_t'(2'(i));
            pads.op_mode_strap           <= rcs_lvl_t'(2'(i));
            pads.signal_detect_threshold <= rcs_lvl_t'(2'(i));
            pads.transmit_disable        <= i[0];
            settle();
            chk(ana.swing_b_mv, sw[i]);
            chk(ana.swing_a_mv, SWING_LOW_MV);
            chk(ana.opm, op[i]);
            chk({ana.thr_assert_mv, ana.thr_deassert_mv}, th[i]);
            chk({ana.output_a_en, ana.output_b_en}, {1'b1, ~i[0]});
        end
    endtask : sc_pin

    task automatic sc_bus;
        @(posedge pclk);
        pads.mgmt_bus_enable_strap <= LVL_HIGH;
        pads.chan_a_eq_level_bit0  <= LVL_HIGH;
        pads.chan_a_eq_level_bit1  <= LVL_LOW;
        pads.output_swing_select   <= LVL_LOW;
        pads.chan_b_deemph_level   <= LVL_HIGH;
        pads.chan_a_deemph_level   <= LVL_LOW;
        settle();
        chk(s_addr, 8'hc2);
        chk({scl_lv, sda_lv}, 2'b10);
        @(posedge pclk);
        pads.output_swing_select <= LVL_HIGH;
        drv_sda                  <= 1'b1;
        settle();
        chk(s_addr, ADDR_FIXED);
        chk({scl_en, sda_en}, 2'b01);
        chk({ana.swing_a_mv, ana.swing_b_mv}, {2{SWING_HI_MV}});
        apb(1'b1, REG_CTRL, 32'h0009_4321);
        apb(1'b0, REG_CTRL, '0);
        chk(rd, 32'h0009_4321);
        apb(1'b0, REG_STAT, '0);
        chk(rd, 32'h0000_b00d);
        settle();
        chk({ana.eq_a, ana.eq_b}, 8'h12);
        chk(ana.swing_b_mv, SWING_HI_ALT_MV);
        chk({ana.dem_a, ana.dem_b}, 8'h34);
    endtask : sc_bus

    task automatic sc_los;
        @(posedge pclk);
        pads.input_a_present <= 1'b0;
        drv_sda              <= 1'b0;
        drv_scl              <= 1'b1;
        settle();
        chk({los_en, scl_en, sda_en}, 3'b010);
        chk({scl_o, sda_o, los_o}, 3'b000);
        apb(1'b0, REG_STAT, '0);
        chk(rd[7], 1'b1);
        apb(1'b1, REG_CTRL, 32'h0002_0000);
        settle();
        chk(los_en, 1'b1);
        apb(1'b1, REG_CTRL, 32'h0004_0000);
        settle();
        chk(los_en, 1'b0);
        @(posedge pclk);
        pads.input_b_present <= 1'b0;
        pads.op_mode_strap   <= LVL_R20K;
        settle();
        chk(ana.low_power, 1'b0);
        repeat (12) @(posedge pclk);
        @(negedge pclk);
        chk(ana.low_power, 1'b1);
        @(posedge pclk);
        pads.input_a_present <= 1'b1;
        settle();
        chk(ana.low_power, 1'b0);
    endtask : sc_los

    task automatic sc_load(input rcs_lvl_t m, input logic f,
                           input logic [3:0] d, input int n,
                           input logic s);
        int p = 0;
        @(posedge pclk);
        pads.mgmt_bus_enable_strap <= m;
        pads.eeprom_read_request_n <= 1'b1;
        fail                       <= f;
        dly                        <= d;
        settle();
        @(posedge pclk);
        pads.eeprom_read_request_n <= 1'b0;
        repeat (16)
        begin
            @(negedge pclk);
            if (f_start === 1'b1)
            begin
                p++;
                chk(ld_st, 1'b1);
            end
        end
        chk(p, n);
        chk(ld_st, s);
    endtask : sc_load

    ////////////////////////////////////////
    initial
    begin
        err_count = 0;
        compares  = 0;
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = '0;
        pwdata    = '0;
        drv_scl   = 1'b0;
        drv_sda   = 1'b0;
        fail      = 1'b0;
        dly       = 4'h2;
        pads      = '0;
        pads.eeprom_read_request_n = 1'b1;
        pads.input_a_present       = 1'b1;
        pads.input_b_present       = 1'b1;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        sc_regs();
        sc_cfg();
        sc_pin();
        sc_bus();
        sc_los();
        sc_load(LVL_LOW, 1'b0, 4'h2, 0, 1'b1);
        sc_load(LVL_FLOAT, 1'b0, 4'h2, 1, 1'b0);
        sc_load(LVL_FLOAT, 1'b1, 4'h5, 1, 1'b1);
        sc_load(LVL_FLOAT, 1'b0, 4'h5, 1, 1'b0);
        close_out();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        close_out();
    end
endmodule : tb
